// [shared/rss_defs.svh]
// rss_defs.svh: register offsets, field positions, reset values and timing figures
// assumes inclusion by bare name from any file of the reset source sequencer
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

// register bus geometry, byte addresses of 32-bit words
`define RSS_ADDR_W 5
`define RSS_OFF_CAUSE 5'h00
`define RSS_OFF_IRQ_STATUS 5'h04
`define RSS_OFF_IRQ_MASK 5'h08
`define RSS_OFF_STATE 5'h0C

// reset cause field positions, shared by status and mask
`define RSS_BIT_POR 0
`define RSS_BIT_EXT 1
`define RSS_BIT_BOD 2
`define RSS_BIT_WDT 3
`define RSS_FLAG_W 4

// reset values
`define RSS_CAUSE_RESET 4'h0
`define RSS_IRQ_STATUS_RESET 4'h0
`define RSS_IRQ_MASK_RESET 4'h0

// bus answers
`define RSS_RESP_OKAY 2'h0
`define RSS_RESP_SLVERR 2'h2

// timing: clock period and documented or default times
`define RSS_MCLK_PERIOD_NS 100
`define RSS_EXT_MIN_NS 1500
`define RSS_TOUT0_US 4
`define RSS_TOUT1_US 64
`define RSS_TOUT2_US 4096
`define RSS_TOUT3_US 65536

`endif

// [shared/rss_pkg.sv]
// rss_pkg: types of the reset source sequencer
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package rss_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        ST_HOLD,
        ST_DELAY,
        ST_RUN,
        ST_WDT
    } rss_state_t;

    // bus response code
    typedef logic [1:0] rss_resp_t;

    // start-up delay selection fuses
    typedef logic [1:0] rss_sel_t;

endpackage

`default_nettype wire

// [hw/rss_source_sync.sv]
// rss_source_sync: per-source synchronisers plus a clockless reset hold
// assumes raw levels from pins or analog comparators, active high, unrelated to mclk
`timescale 1ns/100ps
`default_nettype none

module rss_source_sync #(
    parameter int WIDTH = 3
) (
    // clock and bus reset
    input wire logic mclk,
    input wire logic reset,
    // raw asynchronous source levels, active high
    input wire logic [WIDTH-1:0] raw,
    // synchronised levels and the asynchronous hold
    output logic [WIDTH-1:0] synced,
    output logic hold
);

    logic any_raw;
    logic hold_meta;

    // any active source sets the hold without a clock edge
    assign any_raw = reset | (|raw);

    // two flip-flops per source before any logic reads it
    for (genvar i = 0; i < WIDTH; i++) begin : g_sync
        logic meta;
        logic sync;
        always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
                meta <= 1'b0;
                sync <= 1'b0;
            end else begin
                meta <= raw[i];
                sync <= meta;
            end
        end
        assign synced[i] = sync;
    end

    // hold asserts asynchronously, releases through two edges to avoid a runt release
    always_ff @(posedge mclk or posedge any_raw) begin
        if (any_raw) begin
            hold_meta <= 1'b1;
            hold <= 1'b1;
        end else begin
            hold_meta <= 1'b0;
            hold <= hold_meta;
        end
    end

endmodule

`default_nettype wire

// [hw/rss_reset_sequencer.sv]
// rss_reset_sequencer: combines the reset sources, stretches the internal reset
// through a start-up delay and keeps the reset cause flags for software.
// assumes an AXI4-Lite master on mclk; supply, pin and brown-out levels arrive raw,
// watchdog timeout and enable come from logic on mclk.
//
// Operation
// - Reset loads defaults; release starts vector fetch.
// - Ports reset at once by supply, pin or brown-out, clockless; not by watchdog.
// - Internal reset held through fuse-selected start-up delay.
// - Exactly four sources: supply, pin, watchdog, brown-out.
// - Long pin low resets; short pulses may not.
// - Low supply asserts reset at once, no delay.
// - Enabled brown-out resets immediately; disabled never does.
// - Watchdog gives one-cycle pulse; delay follows it.
// - Bit 3 watchdog flag; cleared by supply, zero-write.
// - Bit 2 brown-out flag; cleared by supply, zero-write.
// - Bit 1 pin flag; cleared by supply, zero-write.
// - Bit 0 supply flag; cleared by zero-write or bus reset.
`timescale 1ns/100ps
`default_nettype none
`include "rss_defs.svh"

module rss_reset_sequencer #(
    parameter int TOUT0_CYCLES = `RSS_TOUT0_US * 1000 / `RSS_MCLK_PERIOD_NS,
    parameter int TOUT1_CYCLES = `RSS_TOUT1_US * 1000 / `RSS_MCLK_PERIOD_NS,
    parameter int TOUT2_CYCLES = `RSS_TOUT2_US * 1000 / `RSS_MCLK_PERIOD_NS,
    parameter int TOUT3_CYCLES = `RSS_TOUT3_US * 1000 / `RSS_MCLK_PERIOD_NS
) (
    // clock and bus reset
    input wire logic mclk,
    input wire logic reset,
    // reset sources
    input wire logic supply_low,
    input wire logic ext_reset_n,
    input wire logic brownout_low,
    input wire logic brownout_enable_fuse,
    input wire logic watchdog_timeout,
    input wire logic watchdog_enable,
    // start-up delay selection
    input wire rss_pkg::rss_sel_t clock_select_fuses,
    // reset outputs
    output logic io_reset,
    output logic core_reset,
    output logic reset_vector_fetch,
    output logic irq,
    // axi4-lite write address
    input wire logic [`RSS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output rss_pkg::rss_resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [`RSS_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output rss_pkg::rss_resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    import rss_pkg::*;

    // cycle counts derived from times; a least time rounds up
    localparam int EXT_MIN_CYC =
        (`RSS_EXT_MIN_NS + `RSS_MCLK_PERIOD_NS - 1) / `RSS_MCLK_PERIOD_NS;
    localparam int EXT_CNT_W = $clog2(EXT_MIN_CYC + 1);
    localparam int CNT_W = 20;
    localparam int FW = `RSS_FLAG_W;

    // synchronised sources
    logic [2:0] raw_src;
    logic [2:0] sync_src;
    logic por_s;
    logic ext_s;
    logic bod_s;
    logic hold;

    // pin filter
    logic [EXT_CNT_W-1:0] ext_cnt;
    logic ext_qual;

    // sequencer
    rss_state_t state;
    rss_state_t next_state;
    logic [CNT_W-1:0] delay_cnt;
    logic [CNT_W-1:0] delay_load;
    logic src_active;
    logic wdt_fire;
    logic run;

    // flags and interrupt registers
    logic [FW-1:0] cause;
    logic [FW-1:0] cause_set;
    logic [FW-1:0] cause_clr;
    logic [FW-1:0] src_now;
    logic [FW-1:0] src_prev;
    logic [FW-1:0] src_evt;
    logic [FW-1:0] irq_status;
    logic [FW-1:0] irq_mask;
    logic [FW-1:0] irq_w1c;

    // bus slave state
    logic aw_held;
    logic w_held;
    logic [`RSS_ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic w_strb0_q;
    logic do_write;
    logic [`RSS_ADDR_W-1:0] wr_word;
    logic wr_cause;
    logic wr_status;
    logic wr_mask;
    logic wr_hit;
    logic [32:0] rd_word;

    // raw sources; a brown-out disabled by its fuse never reaches the logic
    assign raw_src[0] = supply_low;
    assign raw_src[1] = ~ext_reset_n;
    assign raw_src[2] = brownout_low & brownout_enable_fuse;

    // synchronisers and clockless hold of the I/O reset
    rss_source_sync #(
        .WIDTH(3)
    ) u_sync (
        .mclk(mclk),
        .reset(reset),
        .raw(raw_src),
        .synced(sync_src),
        .hold(hold)
    );

    assign por_s = sync_src[0];
    assign ext_s = sync_src[1];
    assign bod_s = sync_src[2];

    // ports go to their initial state as soon as the hold sets
    assign io_reset = hold;

    // pin low must last the minimum width; shorter glitches only blip the hold
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ext_cnt <= '0;
        end else if (!ext_s) begin
            ext_cnt <= '0;
        end else if (ext_cnt != EXT_CNT_W'(EXT_MIN_CYC)) begin
            ext_cnt <= ext_cnt + EXT_CNT_W'(1);
        end
    end

    assign ext_qual = (ext_cnt == EXT_CNT_W'(EXT_MIN_CYC));

    // the three sources that keep the sequencer in reset; the watchdog acts through its own state
    assign src_active = por_s | bod_s | ext_qual;

    // watchdog timeout acts only while enabled and while the core runs
    assign wdt_fire = watchdog_timeout & watchdog_enable & (state == ST_RUN);

    // delay length from the selection fuses, counted down to zero
    always_comb begin
        case (clock_select_fuses)
            2'h0: delay_load = CNT_W'(TOUT0_CYCLES - 1);
            2'h1: delay_load = CNT_W'(TOUT1_CYCLES - 1);
            2'h2: delay_load = CNT_W'(TOUT2_CYCLES - 1);
            default: delay_load = CNT_W'(TOUT3_CYCLES - 1);
        endcase
    end

    // next state: any active source returns to hold without waiting
    always_comb begin
        next_state = state;
        case (state)
            ST_HOLD: begin
                if (!src_active) begin
                    next_state = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (src_active) begin
                    next_state = ST_HOLD;
                end else if (delay_cnt == '0) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (src_active) begin
                    next_state = ST_HOLD;
                end else if (wdt_fire) begin
                    next_state = ST_WDT;
                end
            end
            ST_WDT: begin
                // one-cycle pulse; the delay starts as it ends
                next_state = src_active ? ST_HOLD : ST_DELAY;
            end
            default: begin
                next_state = ST_HOLD;
            end
        endcase
    end

    // state register; bus reset starts from hold so the delay always runs
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state <= ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // delay counter is loaded on every entry to the delay state
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            delay_cnt <= '0;
        end else if (next_state == ST_DELAY && state != ST_DELAY) begin
            delay_cnt <= delay_load;
        end else if (state == ST_DELAY && delay_cnt != '0) begin
            delay_cnt <= delay_cnt - CNT_W'(1);
        end
    end

    // run flag and the fetch pulse at the end of the internal reset
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            run <= 1'b0;
            reset_vector_fetch <= 1'b0;
        end else begin
            run <= (next_state == ST_RUN);
            reset_vector_fetch <= (next_state == ST_RUN) && (state != ST_RUN);
        end
    end

    // the hold term makes supply loss reach the core before any clock edge
    assign core_reset = hold | ~run;

    // source levels and their rising edges, in cause field order
    assign src_now[`RSS_BIT_POR] = por_s;
    assign src_now[`RSS_BIT_EXT] = ext_qual;
    assign src_now[`RSS_BIT_BOD] = bod_s;
    assign src_now[`RSS_BIT_WDT] = wdt_fire;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            src_prev <= '0;
        end else begin
            src_prev <= src_now;
        end
    end

    assign src_evt = src_now & ~src_prev;

    // write decode for the completing write
    assign do_write = aw_held & w_held & ~s_axi_bvalid;
    assign wr_word = {aw_addr_q[`RSS_ADDR_W-1:2], 2'b00};
    assign wr_cause = do_write & w_strb0_q & (wr_word == `RSS_OFF_CAUSE);
    assign wr_status = do_write & w_strb0_q & (wr_word == `RSS_OFF_IRQ_STATUS);
    assign wr_mask = do_write & w_strb0_q & (wr_word == `RSS_OFF_IRQ_MASK);
    assign wr_hit = (wr_word == `RSS_OFF_CAUSE) || (wr_word == `RSS_OFF_IRQ_STATUS) ||
                    (wr_word == `RSS_OFF_IRQ_MASK) || (wr_word == `RSS_OFF_STATE);

    // a zero written clears a flag, a one leaves it alone
    assign cause_clr = wr_cause ? ~w_data_q[FW-1:0] : '0;

    // sources set their own flag only; the supply flag is never set here
    assign cause_set[`RSS_BIT_POR] = 1'b0;
    assign cause_set[`RSS_BIT_EXT] = ext_qual;
    assign cause_set[`RSS_BIT_BOD] = bod_s;
    assign cause_set[`RSS_BIT_WDT] = wdt_fire;

    // cause flags: low supply sets bit 0 and wipes the others; otherwise set wins
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cause <= `RSS_CAUSE_RESET;
        end else if (por_s) begin
            cause <= FW'(1) << `RSS_BIT_POR;
        end else begin
            cause <= (cause & ~cause_clr) | cause_set;
        end
    end

    // interrupt status: sticky on source edges, write one to clear, set wins
    assign irq_w1c = wr_status ? w_data_q[FW-1:0] : '0;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq_status <= `RSS_IRQ_STATUS_RESET;
        end else begin
            irq_status <= (irq_status & ~irq_w1c) | src_evt;
        end
    end

    // interrupt mask, same layout as the status
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq_mask <= `RSS_IRQ_MASK_RESET;
        end else if (wr_mask) begin
            irq_mask <= w_data_q[FW-1:0];
        end
    end

    // level interrupt while any unmasked status bit stands
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_status & ~irq_w1c) | src_evt) & irq_mask);
        end
    end

    // write channels are taken independently and held until both are present
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            aw_held <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            w_held <= 1'b0;
            w_data_q <= '0;
            w_strb0_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb0_q <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // write response one edge after both halves are held
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RSS_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `RSS_RESP_OKAY : `RSS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read data; bits above the flags read as zero, bit 32 marks a mapped word
    always_comb begin
        case ({s_axi_araddr[`RSS_ADDR_W-1:2], 2'b00})
            `RSS_OFF_CAUSE: rd_word = {1'b1, 28'h0000000, cause};
            `RSS_OFF_IRQ_STATUS: rd_word = {1'b1, 28'h0000000, irq_status};
            `RSS_OFF_IRQ_MASK: rd_word = {1'b1, 28'h0000000, irq_mask};
            `RSS_OFF_STATE: rd_word = {1'b1, 28'h0000000, hold, src_active,
                                       state == ST_DELAY, run};
            default: rd_word = '0;
        endcase
    end

    // one read at a time; the address is refused while the data waits
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `RSS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word[31:0];
            s_axi_rresp <= rd_word[32] ? `RSS_RESP_OKAY : `RSS_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// [bench/rss_reset_sequencer_properties.sv]
// rss_reset_sequencer_properties: timing checks on the reset sequencer ports
// assumes binding into rss_reset_sequencer, one clock domain on mclk
`timescale 1ns/100ps
`default_nettype none

module rss_reset_sequencer_properties #(
    parameter int TOUT0_CYCLES = 40,
    parameter int TOUT1_CYCLES = 640,
    parameter int TOUT2_CYCLES = 40960,
    parameter int TOUT3_CYCLES = 655360
) (
    // clock and bus reset
    input wire logic mclk,
    input wire logic reset,
    // reset sources
    input wire logic supply_low,
    input wire logic ext_reset_n,
    input wire logic brownout_low,
    input wire logic brownout_enable_fuse,
    input wire logic watchdog_timeout,
    input wire logic watchdog_enable,
    input wire rss_pkg::rss_sel_t clock_select_fuses,
    // reset outputs
    input wire logic io_reset,
    input wire logic core_reset,
    input wire logic reset_vector_fetch,
    // read data
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata
);
    import rss_pkg::*;
    int dly;
    int hold_cnt;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    // delay length picked by the fuses
    always_comb begin
        case (clock_select_fuses)
            2'h0: dly = TOUT0_CYCLES;
            2'h1: dly = TOUT1_CYCLES;
            2'h2: dly = TOUT2_CYCLES;
            default: dly = TOUT3_CYCLES;
        endcase
    end

    // counts internal reset cycles once every raw source is idle; the port hold may still stand
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            hold_cnt <= 0;
        end else if (core_reset && !supply_low && ext_reset_n &&
                     !(brownout_low && brownout_enable_fuse)) begin
            hold_cnt <= hold_cnt + 1;
        end else begin
            hold_cnt <= 0;
        end
    end

    // a watchdog timeout seen while running
    sequence wdt_hit;
        watchdog_timeout && watchdog_enable && !core_reset;
    endsequence

    AST_SUPPLY_PORTS: assert property (supply_low |-> io_reset && core_reset)
        else $error("supply low without port reset");
    AST_BOD_PORTS: assert property (brownout_low && brownout_enable_fuse |-> io_reset)
        else $error("brown-out without port reset");
    AST_PIN_PORTS: assert property (!ext_reset_n |-> io_reset)
        else $error("pin low without port reset");
    AST_NO_STRAY: assert property ($rose(io_reset) |->
        supply_low || !ext_reset_n || (brownout_low && brownout_enable_fuse))
        else $error("port reset without a source");
    AST_WDT_HIT: assert property (wdt_hit |=> core_reset [*3])
        else $error("watchdog timeout did not reset the core");
    AST_WDT_OFF: assert property (watchdog_timeout && !watchdog_enable && !core_reset
        && !io_reset |=> !core_reset || io_reset)
        else $error("disabled watchdog reset the core");
    AST_DELAY: assert property ($fell(core_reset) && reset_vector_fetch |-> hold_cnt >= dly)
        else $error("start-up delay too short");
    AST_FETCH: assert property (reset_vector_fetch |-> !core_reset && $past(core_reset))
        else $error("fetch not at reset release");
    AST_FETCH_ONCE: assert property (reset_vector_fetch |=> !reset_vector_fetch)
        else $error("fetch pulse longer than one cycle");
    AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0)
        else $error("upper read bits not zero");
endmodule

bind rss_reset_sequencer rss_reset_sequencer_properties #(
    .TOUT0_CYCLES(TOUT0_CYCLES), .TOUT1_CYCLES(TOUT1_CYCLES),
    .TOUT2_CYCLES(TOUT2_CYCLES), .TOUT3_CYCLES(TOUT3_CYCLES)
) rss_reset_sequencer_properties_inst (
    .mclk, .reset, .supply_low, .ext_reset_n, .brownout_low, .brownout_enable_fuse,
    .watchdog_timeout, .watchdog_enable, .clock_select_fuses, .io_reset, .core_reset,
    .reset_vector_fetch, .s_axi_rvalid, .s_axi_rdata
);

`default_nettype wire

// [bench/rss_source_model.sv]
// rss_source_model: supply monitor, reset pin, brown-out detector and watchdog
// assumes the bench calls dip from one process synchronous to mclk
`timescale 1ns/100ps
`default_nettype none

module rss_source_model (
    // clock
    input wire logic mclk,
    // source levels toward the sequencer
    output logic supply_low,
    output logic ext_reset_n,
    output logic brownout_low,
    output logic watchdog_timeout
);
    // supply starts below level, as at a real power-up
    initial begin
        supply_low = 1'b1;
        ext_reset_n = 1'b1;
        brownout_low = 1'b0;
        watchdog_timeout = 1'b0;
    end

    // drives one source active or idle just after an edge
    task automatic set_src(input int src, input logic v);
        case (src)
            0: supply_low <= v;
            1: ext_reset_n <= !v;
            2: brownout_low <= v;
            default: watchdog_timeout <= v;
        endcase
    endtask

    // holds a source for n cycles; n of 1 on the watchdog gives its one-cycle pulse
    task automatic dip(input int src, input int n);
        @(posedge mclk);
        set_src(src, 1'b1);
        repeat (n) @(posedge mclk);
        set_src(src, 1'b0);
    endtask
endmodule

`default_nettype wire

// [bench/tb_rss_reset_sequencer.sv]
// tb_rss_reset_sequencer: register and reset-source tests of the sequencer
// assumes the source model and the bound checker; short delays for simulation
`timescale 1ns/100ps
`default_nettype none
`include "rss_defs.svh"

module tb_rss_reset_sequencer;
    import rss_pkg::*;
    localparam int TOUT[4] = '{4, 8, 12, 16};
    logic mclk, reset, supply_low, ext_reset_n, brownout_low, brownout_enable_fuse;
    logic watchdog_timeout, watchdog_enable, io_reset, core_reset, reset_vector_fetch, irq;
    rss_sel_t clock_select_fuses;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    rss_resp_t s_axi_bresp, s_axi_rresp;
    int fails, n_checks, cnt;

    rss_source_model rss_source_model_inst (
        .mclk, .supply_low, .ext_reset_n, .brownout_low, .watchdog_timeout
    );

    rss_reset_sequencer #(
        .TOUT0_CYCLES(TOUT[0]), .TOUT1_CYCLES(TOUT[1]),
        .TOUT2_CYCLES(TOUT[2]), .TOUT3_CYCLES(TOUT[3])
    ) rss_reset_sequencer_inst (
        .mclk, .reset, .supply_low, .ext_reset_n, .brownout_low, .brownout_enable_fuse,
        .watchdog_timeout, .watchdog_enable, .clock_select_fuses, .io_reset, .core_reset,
        .reset_vector_fetch, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    // free-running system clock
    initial begin
        mclk = 1'b0;
        forever #(`RSS_MCLK_PERIOD_NS / 2) mclk = ~mclk;
    end

    // prints the counts and the verdict, then stops
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // compares one value, four-state exact
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // bus write; address and data offered together, each dropped once taken
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input rss_resp_t er);
        int n = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        if (s_axi_bvalid !== 1'b1) fails++;
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask

    // bus read with expected data and response
    task automatic rd(input logic [4:0] a, input logic [31:0] exp, input rss_resp_t er);
        int n = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        if (s_axi_rvalid !== 1'b1) fails++;
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk(32'(s_axi_rresp), 32'(er));
    endtask

    // waits, bounded, until the core runs; cnt is the number of edges waited
    task automatic wait_run(output int c);
        c = 0;
        do begin
            @(posedge mclk);
            c++;
        end while (core_reset !== 1'b0 && c < 400);
        if (core_reset !== 1'b0) fails++;
    endtask

    // the whole run stays far below this many cycles
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        give_verdict();
    end

    // main sequence
    initial begin
        reset = 1'b1;
        brownout_enable_fuse = 1'b0;
        watchdog_enable = 1'b0;
        clock_select_fuses = 2'h0;
        s_axi_awaddr = 5'h00;
        s_axi_araddr = 5'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        rss_source_model_inst.dip(0, 5);
        wait_run(cnt);
        rd(`RSS_OFF_CAUSE, 32'h1, `RSS_RESP_OKAY);
        rd(`RSS_OFF_STATE, 32'h1, `RSS_RESP_OKAY);
        rd(`RSS_OFF_IRQ_MASK, `RSS_IRQ_MASK_RESET, `RSS_RESP_OKAY);
        wr(`RSS_OFF_CAUSE, 32'hFFFF_FFFF, `RSS_RESP_OKAY);
        rd(`RSS_OFF_CAUSE, 32'h1, `RSS_RESP_OKAY);
        wr(`RSS_OFF_CAUSE, 32'h0, `RSS_RESP_OKAY);
        rd(`RSS_OFF_CAUSE, 32'h0, `RSS_RESP_OKAY);
        // a disabled watchdog is not a source
        rss_source_model_inst.dip(3, 1);
        repeat (3) @(posedge mclk);
        chk(32'(core_reset), 32'h0);
        // watchdog reset under every delay selection
        watchdog_enable <= 1'b1;
        for (int f = 0; f < 4; f++) begin
            clock_select_fuses <= 2'(f);
            rss_source_model_inst.dip(3, 1);
            wait_run(cnt);
            chk(32'(cnt > TOUT[f] && cnt < TOUT[f] + 5), 32'h1);
        end
        rd(`RSS_OFF_CAUSE, 32'h8, `RSS_RESP_OKAY);
        // interrupt raised, masked and cleared
        wr(`RSS_OFF_IRQ_STATUS, 32'hF, `RSS_RESP_OKAY);
        rss_source_model_inst.dip(3, 1);
        wait_run(cnt);
        rd(`RSS_OFF_IRQ_STATUS, 32'h8, `RSS_RESP_OKAY);
        chk(32'(irq), 32'h0);
        wr(`RSS_OFF_IRQ_MASK, 32'h8, `RSS_RESP_OKAY);
        repeat (2) @(posedge mclk);
        chk(32'(irq), 32'h1);
        wr(`RSS_OFF_IRQ_STATUS, 32'h8, `RSS_RESP_OKAY);
        repeat (2) @(posedge mclk);
        chk(32'(irq), 32'h0);
        wr(`RSS_OFF_CAUSE, 32'h0, `RSS_RESP_OKAY);
        // long pin low, then brown-out disabled and enabled
        rss_source_model_inst.dip(1, 20);
        wait_run(cnt);
        rd(`RSS_OFF_CAUSE, 32'h2, `RSS_RESP_OKAY);
        rss_source_model_inst.dip(2, 20);
        repeat (3) @(posedge mclk);
        chk(32'(core_reset), 32'h0);
        brownout_enable_fuse <= 1'b1;
        rss_source_model_inst.dip(2, 20);
        wait_run(cnt);
        rd(`RSS_OFF_CAUSE, 32'h6, `RSS_RESP_OKAY);
        wr(`RSS_OFF_CAUSE, 32'h4, `RSS_RESP_OKAY);
        rd(`RSS_OFF_CAUSE, 32'h4, `RSS_RESP_OKAY);
        // supply loss wipes the other causes
        rss_source_model_inst.dip(3, 1);
        wait_run(cnt);
        rss_source_model_inst.dip(0, 20);
        wait_run(cnt);
        rd(`RSS_OFF_CAUSE, 32'h1, `RSS_RESP_OKAY);
        wr(5'h10, 32'hF, `RSS_RESP_SLVERR);
        rd(5'h10, 32'h0, `RSS_RESP_SLVERR);
        // bus reset in mid-run restarts the sequence with defaults
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        wait_run(cnt);
        rd(`RSS_OFF_CAUSE, `RSS_CAUSE_RESET, `RSS_RESP_OKAY);
        give_verdict();
    end
endmodule

`default_nettype wire
